// ==== hdl/omrc_top.sv ====
// Oscillator pin mode configuration and oscillator run control registers.
//
// Overview of operation
// - Main pin mode bits 7-6: 00 or 10 port, 01 resonator on both pins, 11 clock on pin two.
// - Sub pin mode bits 5-4: 00/10 port, 01 crystal on both pins, 11 external clock on pin two.
// - Sub drive bits 2-1: 00 low power default, 01 normal, 10 ultra-low, 11 never written.
// - Range bit 0 selects 1 to 10 MHz when 0 and above 10 up to 20 MHz when 1.
// - Main halt at 0 runs the resonator or accepts the clock, at 1 stops it; port unaffected.
// - Run control: main halt bit 7, sub halt bit 6, middle run bit 1, fast halt bit 0, rest 0.
// - Sub halt at 0 runs the crystal or accepts the clock, else stops it; port mode unaffected.
// - Middle run bit stops the middle-speed oscillator at 0 and runs it at 1.
// - Fast halt bit runs the high-speed oscillator at 0 and stops it at 1.
`timescale 1ns/100ps
`include "omrc_consts.svh"
module omrc_top (
    input wire logic CLOCK, // System clock, 250 MHz.
    input wire logic RST, // Asynchronous reset, active high.
    input wire logic [3:0] ADDR, // Register address.
    input wire logic [7:0] WDATA, // Write data.
    input wire logic WR, // Write strobe.
    input wire logic RD, // Read strobe.
    output logic [7:0] RDATA, // Read data, valid the cycle after RD.
    output logic MAIN_OSC_ENABLE, // Main resonator amplifier on.
    output logic MAIN_EXT_CLOCK_ACCEPT, // Main external clock gated through.
    output logic MAIN_IN_IS_PORT, // Main input pin acts as port.
    output logic MAIN_OUT_IS_PORT, // Main output pin acts as port.
    output logic MAIN_HIGH_RANGE, // Main oscillator tuned above 10 MHz.
    output logic SUB_OSC_ENABLE, // Sub crystal amplifier on.
    output logic SUB_EXT_CLOCK_ACCEPT, // Sub external clock gated through.
    output logic SUB_IN_IS_PORT, // Sub input pin acts as port.
    output logic SUB_OUT_IS_PORT, // Sub output pin acts as port.
    output logic [1:0] SUB_DRIVE_MODE, // Sub oscillator drive level.
    output logic MIDDLE_OSC_ENABLE, // Middle-speed on-chip oscillator on.
    output logic FAST_OSC_ENABLE // High-speed on-chip oscillator on.
);
    omrc_pkg::omrc_state_type st_r;
    omrc_pkg::omrc_state_type st_nxt;
    omrc_pkg::omrc_pin_mode_type main_mode;
    omrc_pkg::omrc_pin_mode_type sub_mode;
    omrc_pkg::omrc_pin_ctrl_type main_ctrl;
    omrc_pkg::omrc_pin_ctrl_type sub_ctrl;
    logic [1:0] drive_field;
    logic bad_drive_write;

    // Read mux shared by the register read path.
    function automatic logic [7:0] read_reg(input logic [3:0] a,
                                            input omrc_pkg::omrc_state_type s);
        case (a)
            `OMRC_ADDR_PIN_MODE: read_reg = s.pin_mode_cfg_r;
            `OMRC_ADDR_RUN_CTRL: read_reg = s.run_ctrl_r;
            `OMRC_ADDR_STATUS: read_reg = {7'h00, s.bad_drive_write_r};
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    assign drive_field = WDATA[`OMRC_DRIVE_HI:`OMRC_DRIVE_LO];
    assign bad_drive_write = WR && (ADDR == `OMRC_ADDR_PIN_MODE) &&
                             (drive_field == `OMRC_DRIVE_PROHIBITED);

    // Register writes and reads; a prohibited drive code keeps the old field and flags it.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata_r = 8'h00;
        if (WR && ADDR == `OMRC_ADDR_PIN_MODE) begin
            st_nxt.pin_mode_cfg_r = WDATA & `OMRC_PIN_MODE_MASK;
            if (bad_drive_write) begin
                st_nxt.pin_mode_cfg_r[`OMRC_DRIVE_HI:`OMRC_DRIVE_LO] =
                    st_r.pin_mode_cfg_r[`OMRC_DRIVE_HI:`OMRC_DRIVE_LO];
            end
        end
        if (WR && ADDR == `OMRC_ADDR_RUN_CTRL) begin
            st_nxt.run_ctrl_r = WDATA & `OMRC_RUN_CTRL_MASK;
        end
        // Sticky flag: the set wins over a clearing write in the same cycle.
        if (WR && ADDR == `OMRC_ADDR_STATUS && WDATA[0]) begin
            st_nxt.bad_drive_write_r = 1'b0;
        end
        if (bad_drive_write) begin
            st_nxt.bad_drive_write_r = 1'b1;
        end
        if (RD) begin
            st_nxt.rdata_r = read_reg(ADDR, st_r);
        end
    end

    // State register; all oscillators, the high-speed one included, start halted.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r <= '{pin_mode_cfg_r: `OMRC_PIN_MODE_RESET, run_ctrl_r: `OMRC_RUN_CTRL_RESET,
                      rdata_r: 8'h00, bad_drive_write_r: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    omrc_pin_decode u_main (
        .mode(st_r.pin_mode_cfg_r[`OMRC_MAIN_MODE_HI:`OMRC_MAIN_MODE_LO]),
        .halt(st_r.run_ctrl_r[`OMRC_MAIN_HALT_BIT]),
        .pin_mode(main_mode),
        .ctrl(main_ctrl)
    );

    omrc_pin_decode u_sub (
        .mode(st_r.pin_mode_cfg_r[`OMRC_SUB_MODE_HI:`OMRC_SUB_MODE_LO]),
        .halt(st_r.run_ctrl_r[`OMRC_SUB_HALT_BIT]),
        .pin_mode(sub_mode),
        .ctrl(sub_ctrl)
    );

    // Outputs come straight from register bits through fixed decode only.
    assign RDATA = st_r.rdata_r;
    assign MAIN_OSC_ENABLE = main_ctrl.osc_enable;
    assign MAIN_EXT_CLOCK_ACCEPT = main_ctrl.ext_clock_accept;
    assign MAIN_IN_IS_PORT = main_ctrl.in_pin_is_port;
    assign MAIN_OUT_IS_PORT = main_ctrl.out_pin_is_port;
    assign MAIN_HIGH_RANGE = st_r.pin_mode_cfg_r[`OMRC_RANGE_BIT];
    assign SUB_OSC_ENABLE = sub_ctrl.osc_enable;
    assign SUB_EXT_CLOCK_ACCEPT = sub_ctrl.ext_clock_accept;
    assign SUB_IN_IS_PORT = sub_ctrl.in_pin_is_port;
    assign SUB_OUT_IS_PORT = sub_ctrl.out_pin_is_port;
    assign SUB_DRIVE_MODE = st_r.pin_mode_cfg_r[`OMRC_DRIVE_HI:`OMRC_DRIVE_LO];
    assign MIDDLE_OSC_ENABLE = st_r.run_ctrl_r[`OMRC_MID_RUN_BIT];
    assign FAST_OSC_ENABLE = !st_r.run_ctrl_r[`OMRC_FAST_HALT_BIT];

    // Checks on decode and register behaviour; the decoded modes are read only here.
    // Main oscillation decode.
    main_osc_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
        MAIN_OSC_ENABLE |-> (st_r.pin_mode_cfg_r[7:6] == 2'h1) && !MAIN_IN_IS_PORT)
        else $error("Main resonator enabled outside oscillation mode.");
    main_ext_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
        (st_r.pin_mode_cfg_r[7:6] == 2'h3) |-> MAIN_IN_IS_PORT && !MAIN_OUT_IS_PORT)
        else $error("Main external clock mode pins wrong.");
    main_port_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
        !st_r.pin_mode_cfg_r[6] |-> main_mode == omrc_pkg::OMRC_PIN_PORT &&
            MAIN_IN_IS_PORT && MAIN_OUT_IS_PORT && !MAIN_OSC_ENABLE && !MAIN_EXT_CLOCK_ACCEPT)
        else $error("Main pins not ports in port mode.");
    sub_port_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
        (st_r.pin_mode_cfg_r[4] == 1'b0) |-> SUB_IN_IS_PORT && SUB_OUT_IS_PORT && !SUB_OSC_ENABLE)
        else $error("Sub pins not ports in port mode.");
    sub_osc_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
        (st_r.pin_mode_cfg_r[5:4] == 2'h1) |-> sub_mode == omrc_pkg::OMRC_PIN_OSC &&
            !SUB_IN_IS_PORT && !SUB_OUT_IS_PORT && !SUB_EXT_CLOCK_ACCEPT)
        else $error("Sub pins not given to the crystal in oscillation mode.");
    sub_ext_mode_a: assert property (@(posedge CLOCK) disable iff (RST)
        (st_r.pin_mode_cfg_r[5:4] == 2'h3) |-> sub_mode == omrc_pkg::OMRC_PIN_EXT &&
            SUB_IN_IS_PORT && !SUB_OUT_IS_PORT && !SUB_OSC_ENABLE)
        else $error("Sub external clock mode pins wrong.");
    drive_legal_a: assert property (@(posedge CLOCK) disable iff (RST)
        bad_drive_write |=> $stable(SUB_DRIVE_MODE) && st_r.bad_drive_write_r)
        else $error("Prohibited drive code reached the oscillator.");
    drive_code_a: assert property (@(posedge CLOCK) disable iff (RST)
        SUB_DRIVE_MODE != `OMRC_DRIVE_PROHIBITED)
        else $error("Prohibited drive code shown to the oscillator.");
    flag_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
        (WR && ADDR == `OMRC_ADDR_STATUS && WDATA[0]) |=> !st_r.bad_drive_write_r)
        else $error("Prohibited drive flag not cleared.");
    range_write_a: assert property (@(posedge CLOCK) disable iff (RST)
        (WR && ADDR == `OMRC_ADDR_PIN_MODE) |=> MAIN_HIGH_RANGE == $past(WDATA[0]))
        else $error("Range bit did not follow write.");
    main_halt_a: assert property (@(posedge CLOCK) disable iff (RST)
        st_r.run_ctrl_r[7] |-> !MAIN_OSC_ENABLE && !MAIN_EXT_CLOCK_ACCEPT)
        else $error("Main oscillator active while halted.");
    main_run_a: assert property (@(posedge CLOCK) disable iff (RST)
        (st_r.pin_mode_cfg_r[6] && !st_r.run_ctrl_r[7]) |->
            (MAIN_OSC_ENABLE != MAIN_EXT_CLOCK_ACCEPT))
        else $error("Main source not running while released.");
    run_reserved_a: assert property (@(posedge CLOCK) disable iff (RST)
        (RD && ADDR == `OMRC_ADDR_RUN_CTRL) |=> RDATA[5:2] == 4'h0)
        else $error("Reserved run control bits read non-zero.");
    run_write_a: assert property (@(posedge CLOCK) disable iff (RST)
        (WR && ADDR == `OMRC_ADDR_RUN_CTRL) |=>
            st_r.run_ctrl_r == ($past(WDATA) & `OMRC_RUN_CTRL_MASK))
        else $error("Run control write did not land.");
    sub_halt_a: assert property (@(posedge CLOCK) disable iff (RST)
        (st_r.pin_mode_cfg_r[5:4] == 2'h3 && !st_r.run_ctrl_r[6]) |-> SUB_EXT_CLOCK_ACCEPT)
        else $error("Sub external clock not accepted while running.");
    sub_stop_a: assert property (@(posedge CLOCK) disable iff (RST)
        st_r.run_ctrl_r[6] |-> !SUB_OSC_ENABLE && !SUB_EXT_CLOCK_ACCEPT)
        else $error("Sub oscillator active while halted.");
    middle_run_a: assert property (@(posedge CLOCK) disable iff (RST)
        (WR && ADDR == `OMRC_ADDR_RUN_CTRL) |=> MIDDLE_OSC_ENABLE == $past(WDATA[1]))
        else $error("Middle oscillator enable did not follow write.");
    middle_stop_a: assert property (@(posedge CLOCK) disable iff (RST)
        !st_r.run_ctrl_r[`OMRC_MID_RUN_BIT] |-> !MIDDLE_OSC_ENABLE)
        else $error("Middle oscillator running while disabled.");
    fast_halt_a: assert property (@(posedge CLOCK) disable iff (RST)
        (WR && ADDR == `OMRC_ADDR_RUN_CTRL) |=> FAST_OSC_ENABLE == !$past(WDATA[0]))
        else $error("Fast oscillator halt did not follow write.");
    fast_stop_a: assert property (@(posedge CLOCK) disable iff (RST)
        st_r.run_ctrl_r[`OMRC_FAST_HALT_BIT] |-> !FAST_OSC_ENABLE)
        else $error("Fast oscillator running while halted.");
    // Read data stand for one cycle only, so a stale value cannot be taken twice.
    rdata_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
        !RD |=> RDATA == 8'h00)
        else $error("Read data shown without a read.");
    // Main scenarios worth seeing at least once.
    cover_main_osc: cover property (@(posedge CLOCK) disable iff (RST) MAIN_OSC_ENABLE);
    cover_sub_ext: cover property (@(posedge CLOCK) disable iff (RST) SUB_EXT_CLOCK_ACCEPT);
    cover_bad_drive: cover property (@(posedge CLOCK) disable iff (RST) bad_drive_write);
    cover_fast_off: cover property (@(posedge CLOCK) disable iff (RST) !FAST_OSC_ENABLE);
    cover_flag_clear: cover property (@(posedge CLOCK) disable iff (RST)
        WR && ADDR == `OMRC_ADDR_STATUS && st_r.bad_drive_write_r);
endmodule : omrc_top

// ==== hdl/omrc_consts.svh ====
// Register offsets, field positions, reset values and write masks for the oscillator control.
`ifndef OMRC_CONSTS_SVH
`define OMRC_CONSTS_SVH
`define OMRC_ADDR_PIN_MODE 4'h0
`define OMRC_ADDR_RUN_CTRL 4'h1
`define OMRC_ADDR_STATUS 4'h2
`define OMRC_PIN_MODE_RESET 8'h00
`define OMRC_RUN_CTRL_RESET 8'hC1
`define OMRC_RUN_CTRL_MASK 8'hC3
`define OMRC_PIN_MODE_MASK 8'hF7
`define OMRC_MAIN_MODE_HI 7
`define OMRC_MAIN_MODE_LO 6
`define OMRC_SUB_MODE_HI 5
`define OMRC_SUB_MODE_LO 4
`define OMRC_DRIVE_HI 2
`define OMRC_DRIVE_LO 1
`define OMRC_RANGE_BIT 0
`define OMRC_MAIN_HALT_BIT 7
`define OMRC_SUB_HALT_BIT 6
`define OMRC_MID_RUN_BIT 1
`define OMRC_FAST_HALT_BIT 0
`define OMRC_DRIVE_PROHIBITED 2'h3
`endif

// ==== hdl/omrc_pkg.sv ====
// Types shared by the oscillator mode and run control block.
package omrc_pkg;
    typedef enum logic [1:0] {
        OMRC_PIN_PORT,
        OMRC_PIN_OSC,
        OMRC_PIN_EXT
    } omrc_pin_mode_type;

    typedef enum logic [1:0] {
        OMRC_DRV_LOW_POWER,
        OMRC_DRV_NORMAL,
        OMRC_DRV_ULTRA_LOW
    } omrc_drive_type;

    typedef struct packed {
        logic osc_enable;
        logic ext_clock_accept;
        logic in_pin_is_port;
        logic out_pin_is_port;
    } omrc_pin_ctrl_type;

    typedef struct packed {
        logic [7:0] pin_mode_cfg_r;
        logic [7:0] run_ctrl_r;
        logic [7:0] rdata_r;
        logic bad_drive_write_r;
    } omrc_state_type;
endpackage : omrc_pkg

// ==== hdl/omrc_pin_decode.sv ====
// Decoder from a pin mode field and a halt bit to pin and oscillator controls.
`timescale 1ns/100ps
module omrc_pin_decode (
    input wire logic [1:0] mode, // Two-bit pin mode field.
    input wire logic halt, // Oscillator halt bit.
    output omrc_pkg::omrc_pin_mode_type pin_mode, // Decoded mode.
    output omrc_pkg::omrc_pin_ctrl_type ctrl // Pin and oscillator controls.
);
    // Codes 00 and 10 both mean port mode; only the low bit enables the pins.
    always_comb begin
        case (mode)
            2'h1: pin_mode = omrc_pkg::OMRC_PIN_OSC;
            2'h3: pin_mode = omrc_pkg::OMRC_PIN_EXT;
            default: pin_mode = omrc_pkg::OMRC_PIN_PORT;
        endcase
    end

    // The halt bit has no effect in port mode, so the pins stay ports.
    always_comb begin
        ctrl.osc_enable = (pin_mode == omrc_pkg::OMRC_PIN_OSC) && !halt;
        ctrl.ext_clock_accept = (pin_mode == omrc_pkg::OMRC_PIN_EXT) && !halt;
        ctrl.in_pin_is_port = (pin_mode != omrc_pkg::OMRC_PIN_OSC);
        ctrl.out_pin_is_port = (pin_mode == omrc_pkg::OMRC_PIN_PORT);
    end
endmodule : omrc_pin_decode

// ==== tb/omrc_osc_model.sv ====
// Behavioural resonator or external clock source standing on one pair of clock pins.
`timescale 1ns/100ps
module omrc_osc_model (
    input wire logic osc_en, // Amplifier enabled by the block.
    input wire logic ext_en, // External clock accepted by the block.
    output logic [7:0] edges // Pin clock edges seen so far.
);
    // The pin clock runs only while enabled, else it stands still.
    initial edges = 8'h00;
    always #25 if (osc_en || ext_en) edges = edges + 8'h01;
endmodule : omrc_osc_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the oscillator mode and run control registers.
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [10:0] o;
    logic [1:0] drv;
    logic [7:0] mcnt;
    logic [7:0] scnt;
    logic [7:0] d;
    int error_cnt = 0;
    int tests_run = 0;
    int pm = 0;
    int rc = 'hC1;
    int st = 0;
    int exp_q[$];
    // Clock of 4 ns period.
    always #2 clock = ~clock;
    omrc_top dut_u (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .MAIN_OSC_ENABLE(o[0]), .MAIN_EXT_CLOCK_ACCEPT(o[1]),
        .MAIN_IN_IS_PORT(o[2]), .MAIN_OUT_IS_PORT(o[3]), .MAIN_HIGH_RANGE(o[4]),
        .SUB_OSC_ENABLE(o[5]), .SUB_EXT_CLOCK_ACCEPT(o[6]), .SUB_IN_IS_PORT(o[7]),
        .SUB_OUT_IS_PORT(o[8]), .SUB_DRIVE_MODE(drv), .MIDDLE_OSC_ENABLE(o[9]),
        .FAST_OSC_ENABLE(o[10]));
    omrc_osc_model osc_u (.osc_en(o[0]), .ext_en(o[1]), .edges(mcnt));
    omrc_osc_model osc_sub_u (.osc_en(o[5]), .ext_en(o[6]), .edges(scnt));
    // Verdict and end of run, shared by the main sequence and the watchdog.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Write one register and update the model; a write of drive 11 keeps the old drive.
    task automatic wr_reg(logic [3:0] a, logic [7:0] v);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
        if (a == 4'h0 && v[2:1] == 2'h3) st = 1;
        if (a == 4'h0) pm = (v[2:1] == 2'h3) ? ((v & 'hF1) | (pm & 'h06)) : (v & 'hF7);
        if (a == 4'h1) rc = v & 'hC3;
        if (a == 4'h2 && v[0]) st = 0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, then fall back to zero.
    task automatic rd_chk(logic [3:0] a);
        int e;
        exp_q.push_back((a == 4'h0) ? pm : (a == 4'h1) ? rc : (a == 4'h2) ? st : 0);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        e = exp_q.pop_front();
        chk("rdata", 16'(e), 16'(rdata));
        @(posedge clock);
        #1;
        chk("rdata idle", 16'h0000, 16'(rdata));
    endtask : rd_chk
    // Decode expected from the model registers, then watch the pin clock source.
    task automatic chk_out();
        logic [10:0] e;
        logic [7:0] c0;
        logic [7:0] c1;
        // Let the register update of the launching edge settle before looking.
        #1;
        e[0] = pm[7:6] == 2'h1 && !rc[7];
        e[1] = pm[7:6] == 2'h3 && !rc[7];
        e[2] = pm[7:6] != 2'h1;
        e[3] = !pm[6];
        e[4] = pm[0];
        e[5] = pm[5:4] == 2'h1 && !rc[6];
        e[6] = pm[5:4] == 2'h3 && !rc[6];
        e[7] = pm[5:4] != 2'h1;
        e[8] = !pm[4];
        e[9] = rc[1];
        e[10] = !rc[0];
        chk("outputs", {3'h0, 2'(pm >> 1), e}, {3'h0, drv, o});
        c0 = mcnt;
        c1 = scnt;
        repeat (12) @(posedge clock);
        chk("main pin clock", 16'(e[0] | e[1]), 16'(mcnt != c0));
        chk("sub pin clock", 16'(e[5] | e[6]), 16'(scnt != c1));
    endtask : chk_out
    // Watchdog against a hung run.
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        void'($urandom(89954));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd_chk(4'h0);
        rd_chk(4'h1);
        chk_out();
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            d = 8'($urandom);
            d[7:4] = 4'(i);
            d[2:1] = 2'(i % 3);
            d[0] = i[4];
            wr_reg(4'h0, d);
            wr_reg(4'h1, 8'($urandom));
            chk_out();
            rd_chk(4'h0);
            rd_chk(4'h1);
        end
        $display("test modes done");
        wr_reg(4'h0, 8'hFF);
        chk_out();
        rd_chk(4'h2);
        wr_reg(4'h2, 8'h01);
        rd_chk(4'h2);
        wr_reg(4'h9, 8'hFF);
        rd_chk(4'h9);
        chk_out();
        $display("test refusals done");
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        pm = 0;
        rc = 'hC1;
        st = 0;
        rd_chk(4'h1);
        chk_out();
        $display("test second reset done");
        report_and_stop();
    end
endmodule : tb_top
